// *** design/dspid_decoder.sv ***
`timescale 1ns/100ps
module dspid_decoder (
  input  wire logic        pclk,        // 50 MHz clock
  input  wire logic        presetn,     // async reset, active low
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb enable
  input  wire logic        pwrite,      // apb direction
  input  wire logic [11:0] paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error on unmapped address
  output dspid_pkg::dspid_op_t op,      // decoded opcode
  output logic             op_valid,    // decode complete
  output logic             need_second, // waiting for second word
  output logic      [15:0] data_addr,   // direct or indirect operand address
  output logic             frame_sync_mode, // serial frame sync mode flag
  output logic             transmit_mode,   // serial transmit mode flag
  output logic             ext_flag         // external flag output
);
  import dspid_pkg::*;

  typedef enum logic [1:0] {DSPID_IDLE, DSPID_WAIT2} dspid_state_t;

  typedef struct packed {
    dspid_state_t state;
    dspid_op_t    op;
    logic         valid;
    logic         two;
    logic         ind;
    logic         illegal;
    logic [15:0]  word;
    logic [15:0]  second;
    logic [2:0]   aux;
    logic [3:0]   shift;
    logic [1:0]   pm;
    logic [2:0]   sacx;
    logic [3:0]   port;
    logic [8:0]   page;
    logic [2:0]   aux_reg_pointer;
    logic [15:0]  addr;
    logic [7:0]   imm8;
    logic         fsm;
    logic         txm;
    logic         xf;
    logic [31:0]  rdata;
  } dspid_regs_t;

  dspid_regs_t r_reg, r_next;

  logic        acc_set;
  logic        acc_wr;
  logic        acc_rd;
  logic [7:0]  hi;
  dspid_op_t   dop;
  logic        dtwo;
  logic        dmem;
  logic        dill;

  assign acc_set = psel && !penable;
  assign acc_wr  = psel && penable && pwrite;
  assign acc_rd  = psel && penable && !pwrite;
  assign hi      = pwdata[15:8];

  // combinational classification of the written word
  always_comb begin
    dop  = DSPID_OP_NONE;
    dtwo = 1'b0;
    dmem = 1'b0;
    dill = 1'b0;
    unique case (pwdata[15:0])
      DSPID_W_CALL_INDIRECT: dop = DSPID_OP_CALL_INDIRECT;
      DSPID_W_PAC:  dop = DSPID_OP_LOAD_ACC_FROM_PRODUCT;
      DSPID_W_RFS:  dop = DSPID_OP_CLEAR_FRAME_SYNC_MODE;
      DSPID_W_SFS:  dop = DSPID_OP_SET_FRAME_SYNC_MODE;
      DSPID_W_RTX:  dop = DSPID_OP_CLEAR_TRANSMIT_MODE;
      DSPID_W_STX:  dop = DSPID_OP_SET_TRANSMIT_MODE;
      DSPID_W_RXF:  dop = DSPID_OP_CLEAR_EXT_FLAG;
      DSPID_W_SXF:  dop = DSPID_OP_SET_EXT_FLAG;
      default: begin
        unique case (hi)
          8'hff:   dop = DSPID_OP_BRANCH;
          8'hfe:   dop = DSPID_OP_CALL;
          8'hfb:   dop = DSPID_OP_BRANCH_AUX_NONZERO;
          8'hf4:   dop = DSPID_OP_BRANCH_ACC_GE_ZERO;
          8'hf1:   dop = DSPID_OP_BRANCH_ACC_GT_ZERO;
          8'hf2:   dop = DSPID_OP_BRANCH_ACC_LE_ZERO;
          8'hf3:   dop = DSPID_OP_BRANCH_ACC_LT_ZERO;
          8'hf5:   dop = DSPID_OP_BRANCH_ACC_NONZERO;
          8'hf6:   dop = DSPID_OP_BRANCH_ACC_ZERO;
          8'hf8:   dop = DSPID_OP_BRANCH_TC_CLEAR;
          8'hf9:   dop = DSPID_OP_BRANCH_TC_SET;
          8'h5e:   dop = DSPID_OP_BRANCH_ON_CARRY;
          8'h5f:   dop = DSPID_OP_BRANCH_NO_CARRY;
          8'hf0:   dop = DSPID_OP_BRANCH_ON_OVERFLOW;
          8'hf7:   dop = DSPID_OP_BRANCH_NO_OVERFLOW;
          8'hfa:   dop = DSPID_OP_BRANCH_IO_LOW;
          8'h5d:   dop = DSPID_OP_MULT_ACCUMULATE;
          8'h5c:   dop = DSPID_OP_MULT_ACC_DATA_MOVE;
          8'hfd:   dop = DSPID_OP_BLOCK_MOVE_DATA;
          8'hfc:   dop = DSPID_OP_BLOCK_MOVE_PROGRAM;
          8'h7e:   dop = DSPID_OP_ADD_AUX_IMM;
          8'h7f:   dop = DSPID_OP_SUB_AUX_IMM;
          8'h38:   dop = DSPID_OP_MULTIPLY_TEMP;
          8'h56:   dop = DSPID_OP_DATA_WORD_MOVE;
          default: begin
            // product shift mode: ce08..ce0b
            if (pwdata[15:2] == 14'h3382) begin
              dop = DSPID_OP_SET_PRODUCT_SHIFT;
            end else if (pwdata[15:9] == 7'b1100100) begin
              dop = DSPID_OP_LOAD_PAGE_IMM;
            end else if (pwdata[15:11] == 5'b11000) begin
              dop = DSPID_OP_LOAD_AUX_SHORT_IMM;
            end else if (pwdata[15:11] == 5'b11010) begin
              // a nonzero low byte is not a legal long load
              if (pwdata[7:0] == 8'h00) begin
                dop = DSPID_OP_LOAD_AUX_LONG_IMM;
              end else begin
                dill = 1'b1;
              end
            end else if (pwdata[15:11] == 5'b00110) begin
              dop = DSPID_OP_LOAD_AUX_REG;
            end else if (pwdata[15:11] == 5'b01110) begin
              dop = DSPID_OP_STORE_AUX_REG;
            end else if (pwdata[15:12] == 4'b1000) begin
              dop = DSPID_OP_PORT_IN;
            end else if (pwdata[15:12] == 4'b1110) begin
              dop = DSPID_OP_PORT_OUT;
            end else if (pwdata[15:11] == 5'b01101) begin
              dop = pwdata[10] ? DSPID_OP_STORE_ACC_LOW : DSPID_OP_STORE_ACC_HIGH;
            end else if (pwdata[15:12] == 4'b0010) begin
              dop = DSPID_OP_ACC_SHIFT;
            end else begin
              dill = 1'b1;
            end
          end
        endcase
      end
    endcase
    // word count and operand kind follow from the class alone
    unique case (dop)
      DSPID_OP_BRANCH, DSPID_OP_CALL, DSPID_OP_BRANCH_AUX_NONZERO, DSPID_OP_BRANCH_ACC_GE_ZERO,
      DSPID_OP_BRANCH_ACC_GT_ZERO, DSPID_OP_BRANCH_ACC_LE_ZERO, DSPID_OP_BRANCH_ACC_LT_ZERO,
      DSPID_OP_BRANCH_ACC_NONZERO, DSPID_OP_BRANCH_ACC_ZERO, DSPID_OP_BRANCH_TC_CLEAR,
      DSPID_OP_BRANCH_TC_SET, DSPID_OP_BRANCH_ON_CARRY, DSPID_OP_BRANCH_NO_CARRY,
      DSPID_OP_BRANCH_ON_OVERFLOW, DSPID_OP_BRANCH_NO_OVERFLOW, DSPID_OP_BRANCH_IO_LOW,
      DSPID_OP_LOAD_AUX_LONG_IMM: dtwo = 1'b1;
      DSPID_OP_MULT_ACCUMULATE, DSPID_OP_MULT_ACC_DATA_MOVE, DSPID_OP_BLOCK_MOVE_DATA,
      DSPID_OP_BLOCK_MOVE_PROGRAM: begin
        dtwo = 1'b1;
        dmem = 1'b1;
      end
      DSPID_OP_LOAD_AUX_REG, DSPID_OP_STORE_AUX_REG, DSPID_OP_MULTIPLY_TEMP, DSPID_OP_DATA_WORD_MOVE,
      DSPID_OP_PORT_IN, DSPID_OP_PORT_OUT, DSPID_OP_STORE_ACC_HIGH, DSPID_OP_STORE_ACC_LOW,
      DSPID_OP_ACC_SHIFT: dmem = 1'b1;
      default: ;
    endcase
  end

  always_comb begin
    r_next = r_reg;
    r_next.valid = 1'b0;
    if (acc_wr && paddr == DSPID_INSTR_OFS) begin
      if (r_reg.state == DSPID_WAIT2) begin
        // second word completes branch target / long immediate / source
        r_next.second = pwdata[15:0];
        r_next.state  = DSPID_IDLE;
        r_next.valid  = 1'b1;
        if (r_reg.op == DSPID_OP_LOAD_AUX_LONG_IMM) begin
          r_next.addr = pwdata[15:0];
        end
      end else begin
        r_next.word    = pwdata[15:0];
        r_next.op      = dop;
        r_next.two     = dtwo;
        r_next.illegal = dill;
        r_next.aux     = pwdata[10:8];
        r_next.shift   = pwdata[11:8];
        r_next.pm      = pwdata[1:0];
        r_next.sacx    = pwdata[10:8];
        r_next.port    = pwdata[11:8];
        r_next.imm8    = pwdata[7:0];
        r_next.ind     = dmem && pwdata[7];
        if (dmem && !pwdata[7]) begin
          r_next.addr = {r_reg.page, pwdata[6:0]};
        end else if (dmem) begin
          r_next.addr = {13'h0000, r_reg.aux_reg_pointer};
        end else begin
          r_next.addr = {8'h00, pwdata[7:0]};
        end
        if (dop == DSPID_OP_LOAD_PAGE_IMM) begin
          r_next.page = pwdata[8:0];
          r_next.addr = {7'h00, pwdata[8:0]};
        end
        // indirect memory operands update the pointer from bits 2..0 when bit 3 set
        if (dmem && pwdata[7] && pwdata[3]) begin
          r_next.aux_reg_pointer = pwdata[2:0];
        end
        unique case (dop)
          DSPID_OP_CLEAR_FRAME_SYNC_MODE: r_next.fsm = 1'b0;
          DSPID_OP_SET_FRAME_SYNC_MODE:   r_next.fsm = 1'b1;
          DSPID_OP_CLEAR_TRANSMIT_MODE:   r_next.txm = 1'b0;
          DSPID_OP_SET_TRANSMIT_MODE:     r_next.txm = 1'b1;
          DSPID_OP_CLEAR_EXT_FLAG:        r_next.xf  = 1'b0;
          DSPID_OP_SET_EXT_FLAG:          r_next.xf  = 1'b1;
          default: ;
        endcase
        if (dtwo) begin
          r_next.state = DSPID_WAIT2;
        end else begin
          r_next.valid = 1'b1;
        end
      end
    end else if (acc_wr && paddr == DSPID_CTX_OFS) begin
      r_next.page = pwdata[8:0];
      r_next.aux_reg_pointer  = pwdata[DSPID_C_ARP +: 3];
    end
    // read data captured in setup so the access phase answers from flops
    if (acc_set && !pwrite) begin
      unique case (paddr)
        DSPID_INSTR_OFS:  r_next.rdata = {16'h0000, r_reg.word};
        DSPID_STATUS_OFS: r_next.rdata = {27'h0, r_reg.illegal, r_reg.ind, r_reg.two,
                                          r_reg.state == DSPID_WAIT2, r_reg.valid};
        DSPID_OPCODE_OFS: r_next.rdata = {26'h0, r_reg.op};
        DSPID_FIELDS_OFS: r_next.rdata = {12'h0, r_reg.port, 1'b0, r_reg.sacx, 2'b00,
                                          r_reg.pm, r_reg.shift, 1'b0, r_reg.aux};
        DSPID_ADDR_OFS:   r_next.rdata = {8'h00, r_reg.imm8, r_reg.addr};
        DSPID_SECOND_OFS: r_next.rdata = {16'h0000, r_reg.second};
        DSPID_CTX_OFS:    r_next.rdata = {13'h0, r_reg.aux_reg_pointer, 7'h00, r_reg.page};
        DSPID_MODES_OFS:  r_next.rdata = {29'h0, r_reg.xf, r_reg.txm, r_reg.fsm};
        default:          r_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{state: DSPID_IDLE, op: DSPID_OP_NONE, page: DSPID_PAGE_RST,
                 aux_reg_pointer: DSPID_ARP_RST, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  logic mapped;
  assign mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);

  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !mapped;
  assign prdata          = r_reg.rdata;
  assign op              = r_reg.op;
  assign op_valid        = r_reg.valid;
  assign need_second     = r_reg.state == DSPID_WAIT2;
  assign data_addr       = r_reg.addr;
  assign frame_sync_mode = r_reg.fsm;
  assign transmit_mode   = r_reg.txm;
  assign ext_flag        = r_reg.xf;

  property p_two_word_waits;
    @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == DSPID_INSTR_OFS && r_reg.state == DSPID_IDLE && dtwo) |=> need_second && !op_valid;
  endproperty
  a_two_word_waits: assert property (p_two_word_waits) else $error("two-word op did not wait");

  property p_direct_addr;
    @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == DSPID_INSTR_OFS && r_reg.state == DSPID_IDLE && dmem && !pwdata[7])
      |=> data_addr == {$past(r_reg.page), $past(pwdata[6:0])};
  endproperty
  a_direct_addr: assert property (p_direct_addr) else $error("direct address wrong");

  property p_ext_flag;
    @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == DSPID_INSTR_OFS && r_reg.state == DSPID_IDLE && pwdata[15:0] == DSPID_W_SXF)
      |=> ext_flag && op == DSPID_OP_SET_EXT_FLAG && op_valid;
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("external flag not set");

  property p_call_indirect;
    @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == DSPID_INSTR_OFS && r_reg.state == DSPID_IDLE && pwdata[15:0] == DSPID_W_CALL_INDIRECT)
      |=> op == DSPID_OP_CALL_INDIRECT && op_valid;
  endproperty
  a_call_indirect: assert property (p_call_indirect) else $error("indirect call not decoded");

  property p_page_load;
    @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == DSPID_INSTR_OFS && r_reg.state == DSPID_IDLE && pwdata[15:9] == 7'b1100100)
      |=> r_reg.page == $past(pwdata[8:0]);
  endproperty
  a_page_load: assert property (p_page_load) else $error("page pointer not loaded");

  property p_branch_ff;
    @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == DSPID_INSTR_OFS && r_reg.state == DSPID_IDLE && pwdata[15:8] == 8'hff)
      |=> op == DSPID_OP_BRANCH && need_second;
  endproperty
  a_branch_ff: assert property (p_branch_ff) else $error("branch not decoded");

  property p_fsm_clear;
    @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == DSPID_INSTR_OFS && r_reg.state == DSPID_IDLE && pwdata[15:0] == DSPID_W_RFS)
      |=> !frame_sync_mode && op_valid;
  endproperty
  a_fsm_clear: assert property (p_fsm_clear) else $error("frame sync mode not cleared");

  property p_arp_range;
    @(posedge pclk) disable iff (!presetn)
      (op_valid && r_reg.ind) |-> data_addr[15:3] == 13'h0;
  endproperty
  a_arp_range: assert property (p_arp_range) else $error("pointer out of range");
endmodule // dspid_decoder

// *** common/dspid_pkg.sv ***
package dspid_pkg;
  // register byte addresses
  localparam logic [11:0] DSPID_INSTR_OFS   = 12'h000; // write: instruction word
  localparam logic [11:0] DSPID_STATUS_OFS  = 12'h004; // busy / valid / two-word
  localparam logic [11:0] DSPID_OPCODE_OFS  = 12'h008; // decoded opcode
  localparam logic [11:0] DSPID_FIELDS_OFS  = 12'h00c; // aux, shifts, port, mode
  localparam logic [11:0] DSPID_ADDR_OFS    = 12'h010; // data address / immediate
  localparam logic [11:0] DSPID_SECOND_OFS  = 12'h014; // second word
  localparam logic [11:0] DSPID_CTX_OFS     = 12'h018; // page pointer and aux pointer
  localparam logic [11:0] DSPID_MODES_OFS   = 12'h01c; // mode flags
  // status bit positions
  localparam int DSPID_ST_VALID  = 0;
  localparam int DSPID_ST_WAIT2  = 1;
  localparam int DSPID_ST_TWO    = 2;
  localparam int DSPID_ST_IND    = 3;
  localparam int DSPID_ST_ILLEGAL = 4;
  // fields register positions
  localparam int DSPID_F_AUX   = 0;  // 3 bits
  localparam int DSPID_F_SHIFT = 4;  // 4 bits
  localparam int DSPID_F_PM    = 8;  // 2 bits
  localparam int DSPID_F_SACX  = 12; // 3 bits
  localparam int DSPID_F_PORT  = 16; // 4 bits
  // context register positions
  localparam int DSPID_C_ARP  = 16;
  // reset values
  localparam logic [8:0] DSPID_PAGE_RST = 9'h000;
  localparam logic [2:0] DSPID_ARP_RST  = 3'h0;
  // fixed words
  localparam logic [15:0] DSPID_W_CALL_INDIRECT = 16'hce24;
  localparam logic [15:0] DSPID_W_PAC  = 16'hce14;
  localparam logic [15:0] DSPID_W_RFS  = 16'hce36;
  localparam logic [15:0] DSPID_W_SFS  = 16'hce37;
  localparam logic [15:0] DSPID_W_RTX  = 16'hce20;
  localparam logic [15:0] DSPID_W_STX  = 16'hce21;
  localparam logic [15:0] DSPID_W_RXF  = 16'hce0c;
  localparam logic [15:0] DSPID_W_SXF  = 16'hce0d;

  typedef enum logic [5:0] {
    DSPID_OP_NONE, DSPID_OP_CALL_INDIRECT, DSPID_OP_LOAD_ACC_FROM_PRODUCT,
    DSPID_OP_CLEAR_FRAME_SYNC_MODE, DSPID_OP_SET_FRAME_SYNC_MODE,
    DSPID_OP_CLEAR_TRANSMIT_MODE, DSPID_OP_SET_TRANSMIT_MODE,
    DSPID_OP_CLEAR_EXT_FLAG, DSPID_OP_SET_EXT_FLAG,
    DSPID_OP_BRANCH, DSPID_OP_CALL, DSPID_OP_BRANCH_AUX_NONZERO,
    DSPID_OP_BRANCH_ACC_GE_ZERO, DSPID_OP_BRANCH_ACC_GT_ZERO, DSPID_OP_BRANCH_ACC_LE_ZERO,
    DSPID_OP_BRANCH_ACC_LT_ZERO, DSPID_OP_BRANCH_ACC_NONZERO, DSPID_OP_BRANCH_ACC_ZERO,
    DSPID_OP_BRANCH_TC_CLEAR, DSPID_OP_BRANCH_TC_SET, DSPID_OP_BRANCH_ON_CARRY,
    DSPID_OP_BRANCH_NO_CARRY, DSPID_OP_BRANCH_ON_OVERFLOW, DSPID_OP_BRANCH_NO_OVERFLOW,
    DSPID_OP_BRANCH_IO_LOW, DSPID_OP_LOAD_AUX_SHORT_IMM, DSPID_OP_LOAD_AUX_LONG_IMM,
    DSPID_OP_LOAD_PAGE_IMM, DSPID_OP_MULT_ACCUMULATE, DSPID_OP_MULT_ACC_DATA_MOVE,
    DSPID_OP_BLOCK_MOVE_DATA, DSPID_OP_BLOCK_MOVE_PROGRAM, DSPID_OP_LOAD_AUX_REG,
    DSPID_OP_STORE_AUX_REG, DSPID_OP_ADD_AUX_IMM, DSPID_OP_SUB_AUX_IMM,
    DSPID_OP_MULTIPLY_TEMP, DSPID_OP_DATA_WORD_MOVE, DSPID_OP_PORT_IN, DSPID_OP_PORT_OUT,
    DSPID_OP_SET_PRODUCT_SHIFT, DSPID_OP_STORE_ACC_HIGH, DSPID_OP_STORE_ACC_LOW,
    DSPID_OP_ACC_SHIFT
  } dspid_op_t;
endpackage

// *** dv/dspid_pmem.sv ***
`timescale 1ns/100ps
module dspid_pmem (
  input  wire logic        pclk, // processor clock
  input  wire logic [5:0]  pc,   // program word address
  output logic      [15:0] word  // word read one cycle after pc
);
  logic [15:0] mem [0:63];
  logic [15:0] one_word [0:16] = '{16'hce24, 16'hce14, 16'hce36, 16'hce37, 16'hce20, 16'hce21, 16'hce0c,
                                   16'hce0d, 16'h3200, 16'h7600, 16'h7e11, 16'h7f11, 16'h3800, 16'h8a00,
                                   16'hef00, 16'hce0a, 16'h2a00};
  logic [7:0]  ub [0:19]       = '{8'hff, 8'hfe, 8'hfb, 8'hf4, 8'hf1, 8'hf2, 8'hf3, 8'hf5, 8'hf6, 8'hf8,
                                   8'hf9, 8'h5e, 8'h5f, 8'hf0, 8'hf7, 8'hfa, 8'h5d, 8'h5c, 8'hfd, 8'hfc};
  initial begin
    for (int i = 0; i < 17; i++) begin
      mem[i] = one_word[i];
    end
    for (int k = 0; k < 20; k++) begin
      mem[17 + 2 * k] = {ub[k], (k < 16) ? 8'h80 : 8'h00}; // opcode word, then its operand word
      mem[18 + 2 * k] = 16'h1000 + 16'(k);
    end
  end
  always_ff @(posedge pclk) begin
    // past the program the bus shows no stale word, so a fetch too far cannot pass by luck
    if (pc < 6'd57) begin
      word <= mem[pc];
    end else begin
      word <= ~word;
    end
  end
endmodule // dspid_pmem

// *** dv/tb.sv ***
`timescale 1ns/100ps
module tb;
  import dspid_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, op_valid, need_second;
  logic        frame_sync_mode, transmit_mode, ext_flag;
  logic [15:0] data_addr, pm_word, w;
  logic [5:0]  fetch_pc;
  dspid_op_t   op;
  wire  [2:0]  modes = {ext_flag, transmit_mode, frame_sync_mode};
  int          fail_count, n_compared, pc;
  // expected opcodes as positions in the opcode type, in program order
  int exp_code [0:36] = '{1, 2, 3, 4, 5, 6, 7, 8, 32, 33, 34, 35, 36, 38, 39, 40, 43,
                          9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21, 22, 23, 24, 28, 29, 30, 31};

  dspid_decoder u_dspid_decoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op(op), .op_valid(op_valid), .need_second(need_second), .data_addr(data_addr),
    .frame_sync_mode(frame_sync_mode), .transmit_mode(transmit_mode), .ext_flag(ext_flag));
  dspid_pmem u_dspid_pmem (.pclk(pclk), .pc(fetch_pc), .word(pm_word));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_op(input dspid_op_t exp, input dspid_op_t got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch op expected %0d seen %0d", exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_chk(input string nm, input logic [11:0] a, input logic [31:0] msk, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_val(nm, exp, rd & msk);
  endtask

  task automatic issue(input logic [15:0] word);
    apb(1'b1, DSPID_INSTR_OFS, {16'h0000, word});
    #1;
  endtask

  task automatic fetch(output logic [15:0] word);
    @(posedge pclk);
    fetch_pc <= 6'(pc);
    @(posedge pclk);
    #1;
    word = pm_word;
    pc++;
  endtask

  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fetch_pc} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk_op(DSPID_OP_NONE, op);
    chk_val("modes", 32'h0, modes);
    reg_chk("ctx", DSPID_CTX_OFS, 32'h0007_01ff, {13'h0, DSPID_ARP_RST, 7'h0, DSPID_PAGE_RST});
    reg_chk("status", DSPID_STATUS_OFS, 32'hffff_ffff, 32'h0);
    for (int i = 0; i < 37; i++) begin
      fetch(w);
      issue(w);
      if (i >= 17) begin
        chk_val("need_second", 32'h1, need_second);
        fetch(w);
        issue(w);
      end
      if (i < 17) chk_op(dspid_op_t'(exp_code[i]), op);
      else chk_op(dspid_op_t'(exp_code[i]), op);
      chk_val("op_valid", 32'h1, op_valid);
      if (i >= 2 && i < 8) chk_val("mode", 32'(i % 2), modes[(i - 2) / 2]);
      if (i >= 17) reg_chk("second", DSPID_SECOND_OFS, 32'h0000_ffff, {16'h0, w});
    end
    @(posedge pclk);
    #1;
    chk_val("op_valid", 32'h0, op_valid);
    reg_chk("modes", DSPID_MODES_OFS, 32'h7, 32'h7);
    issue(16'hc35a);
    chk_op(DSPID_OP_LOAD_AUX_SHORT_IMM, op);
    reg_chk("aux", DSPID_FIELDS_OFS, 32'h7, 32'h3);
    reg_chk("imm", DSPID_ADDR_OFS, 32'h00ff_0000, 32'h005a_0000);
    issue(16'hc9ab);
    chk_op(DSPID_OP_LOAD_PAGE_IMM, op);
    reg_chk("page", DSPID_CTX_OFS, 32'h1ff, 32'h1ab);
    issue(16'h5645);
    chk_op(DSPID_OP_DATA_WORD_MOVE, op);
    chk_val("data_addr", 32'h0000_d5c5, data_addr);
    reg_chk("ind", DSPID_STATUS_OFS, 32'h8, 32'h0);
    issue(16'h568d);
    reg_chk("ind", DSPID_STATUS_OFS, 32'h8, 32'h8);
    reg_chk("arp", DSPID_CTX_OFS, 32'h0007_0000, 32'h0005_0000);
    issue(16'hd500);
    chk_val("need_second", 32'h1, need_second);
    issue(16'h1234);
    chk_op(DSPID_OP_LOAD_AUX_LONG_IMM, op);
    reg_chk("long", DSPID_ADDR_OFS, 32'h0000_ffff, 32'h0000_1234);
    reg_chk("aux", DSPID_FIELDS_OFS, 32'h7, 32'h5);
    issue(16'h8a00);
    reg_chk("port", DSPID_FIELDS_OFS, 32'h000f_0000, 32'h000a_0000);
    issue(16'hef00);
    reg_chk("port", DSPID_FIELDS_OFS, 32'h000f_0000, 32'h000f_0000);
    issue(16'hce0a);
    reg_chk("pm", DSPID_FIELDS_OFS, 32'h300, 32'h200);
    issue(16'h2a00);
    reg_chk("shift", DSPID_FIELDS_OFS, 32'hf0, 32'ha0);
    issue(16'h6b00);
    chk_op(DSPID_OP_STORE_ACC_HIGH, op);
    reg_chk("sacx", DSPID_FIELDS_OFS, 32'h7000, 32'h3000);
    issue(16'h6f00);
    chk_op(DSPID_OP_STORE_ACC_LOW, op);
    reg_chk("sacx", DSPID_FIELDS_OFS, 32'h7000, 32'h7000);
    // a long load with a nonzero low byte is flagged and waits for no second word
    issue(16'hd501);
    chk_op(DSPID_OP_NONE, op);
    chk_val("need_second", 32'h0, need_second);
    reg_chk("illegal", DSPID_STATUS_OFS, 32'h10, 32'h10);
    // unmapped offset must be refused on the bus
    apb(1'b0, 12'h020, 32'h0);
    chk_val("pslverr", 32'h1, err);
    tally_and_finish();
  end
endmodule // tb
